// ==== verilog/acc_alu_pkg.sv ====
`default_nettype none
package acc_alu_pkg;
    // register map (byte addresses)
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_FIRST_INDEX = 8'h0C;
    localparam logic [7:0] OFS_SECOND_INDEX = 8'h10;
    localparam logic [7:0] OFS_GPR_BASE = 8'h20;
    localparam logic [7:0] OFS_GPR_LAST = 8'h3C;
    localparam int CTRL_GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_BAD_BIT = 1;
    // flag positions
    localparam int FLAG_S = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_H = 4;
    localparam int FLAG_PV = 2;
    localparam int FLAG_N = 1;
    localparam int FLAG_C = 0;
    // opcode fields
    localparam logic [7:0] PREFIX_FIRST = 8'hDD;
    localparam logic [7:0] PREFIX_SECOND = 8'hFD;
    localparam logic [1:0] CLASS_REG = 2'h2;
    localparam logic [1:0] CLASS_IMM = 2'h3;
    localparam logic [2:0] MEM_FIELD = 3'h6;
    localparam logic [2:0] REG_ACC = 3'h7;
    localparam logic [2:0] REG_H = 3'h4;
    localparam logic [2:0] REG_L = 3'h5;
    localparam logic [2:0] GROUP_SUB = 3'h2;
    localparam logic [2:0] GROUP_SUB_BORROW = 3'h3;
    localparam logic [2:0] GROUP_AND = 3'h4;
    localparam logic [2:0] GROUP_OR = 3'h6;
    // timing: one T state is one pclk period
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_STATE_NS = 50;
    localparam int CYC_PER_T = T_STATE_NS / CLK_PERIOD_NS;
    localparam logic [2:0] FETCH_CYC = 3'(4 * CYC_PER_T);
    localparam logic [2:0] READ_CYC = 3'(3 * CYC_PER_T);
    localparam logic [2:0] CALC_CYC = 3'(5 * CYC_PER_T);
    localparam int REG_TOTAL_CYC = 4 * CYC_PER_T;
    localparam int SHORT_TOTAL_CYC = 7 * CYC_PER_T;
    localparam int INDEX_TOTAL_CYC = 19 * CYC_PER_T;
    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum {ST_IDLE, ST_OPCODE, ST_INDEXED_OPCODE, ST_IMMEDIATE,
                  ST_DISPLACEMENT, ST_ADDRESS_CALC, ST_OPERAND} state_type;
endpackage
`default_nettype wire

// ==== verilog/accumulator_sub_and_or_alu.sv ====
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module accumulator_sub_and_or_alu #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic exec_done
);
    acc_alu_pkg::state_type state;
    logic [2:0] tcnt;
    logic [15:0] pc;
    logic [7:0] gpr [0:7];
    logic [7:0] flags;
    logic [15:0] first_index_register;
    logic [15:0] second_index_register;
    logic [2:0] op_field;
    logic use_second;
    logic indexed;
    logic [7:0] disp;
    logic bad_opcode;

    function automatic logic group_ok(input logic [2:0] g);
        return g == acc_alu_pkg::GROUP_SUB || g == acc_alu_pkg::GROUP_SUB_BORROW ||
               g == acc_alu_pkg::GROUP_AND || g == acc_alu_pkg::GROUP_OR;
    endfunction

    // returns {flags, result}
    function automatic logic [15:0] alu(input logic [2:0] g, input logic [7:0] a,
                                        input logic [7:0] s, input logic [7:0] f);
        logic cin;
        logic [8:0] diff;
        logic [4:0] hdiff;
        logic [7:0] res;
        logic [7:0] nf;
        cin = (g == acc_alu_pkg::GROUP_SUB_BORROW) ? f[acc_alu_pkg::FLAG_C] : 1'b0;
        diff = {1'b0, a} - {1'b0, s} - {8'h00, cin};
        hdiff = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, cin};
        nf = f;
        res = a;
        case (g)
            acc_alu_pkg::GROUP_SUB, acc_alu_pkg::GROUP_SUB_BORROW: begin
                res = diff[7:0];
                nf[acc_alu_pkg::FLAG_H] = hdiff[4];
                nf[acc_alu_pkg::FLAG_PV] = (a[7] ^ s[7]) & (a[7] ^ res[7]);
                nf[acc_alu_pkg::FLAG_N] = 1'b1;
                nf[acc_alu_pkg::FLAG_C] = diff[8];
            end
            acc_alu_pkg::GROUP_AND: begin
                res = a & s;
                nf[acc_alu_pkg::FLAG_H] = 1'b1;
                nf[acc_alu_pkg::FLAG_PV] = 1'b0;
                nf[acc_alu_pkg::FLAG_N] = 1'b0;
                nf[acc_alu_pkg::FLAG_C] = 1'b0;
            end
            acc_alu_pkg::GROUP_OR: begin
                res = a | s;
                nf[acc_alu_pkg::FLAG_H] = 1'b0;
                nf[acc_alu_pkg::FLAG_PV] = 1'b0;
                nf[acc_alu_pkg::FLAG_N] = 1'b0;
                nf[acc_alu_pkg::FLAG_C] = 1'b0;
            end
            default: res = a;
        endcase
        nf[acc_alu_pkg::FLAG_S] = res[7];
        nf[acc_alu_pkg::FLAG_Z] = (res == 8'h00);
        return {nf, res};
    endfunction

    // sequencing
    wire [2:0] phase_len = (state == acc_alu_pkg::ST_OPCODE ||
                            state == acc_alu_pkg::ST_INDEXED_OPCODE) ? acc_alu_pkg::FETCH_CYC :
                           (state == acc_alu_pkg::ST_ADDRESS_CALC) ? acc_alu_pkg::CALC_CYC :
                           acc_alu_pkg::READ_CYC;
    wire last_t = (state != acc_alu_pkg::ST_IDLE) && (tcnt == phase_len - 3'h1);
    wire busy = (state != acc_alu_pkg::ST_IDLE);
    wire [7:0] acc = gpr[acc_alu_pkg::REG_ACC];
    wire [15:0] pointer_pair = {gpr[acc_alu_pkg::REG_H], gpr[acc_alu_pkg::REG_L]};
    wire [15:0] index_val = use_second ? second_index_register : first_index_register;
    wire [15:0] index_addr = index_val + {{8{disp[7]}}, disp};

    // opcode decode on the fetched byte
    wire [1:0] byte_class = mem_rdata[7:6];
    wire [2:0] byte_grp = mem_rdata[5:3];
    wire [2:0] byte_low = mem_rdata[2:0];
    wire is_prefix = mem_rdata == acc_alu_pkg::PREFIX_FIRST ||
                     mem_rdata == acc_alu_pkg::PREFIX_SECOND;
    wire grp_valid = group_ok(byte_grp);
    wire is_reg_form = byte_class == acc_alu_pkg::CLASS_REG && grp_valid &&
                       byte_low != acc_alu_pkg::MEM_FIELD;
    wire is_ptr_form = byte_class == acc_alu_pkg::CLASS_REG && grp_valid &&
                       byte_low == acc_alu_pkg::MEM_FIELD;
    wire is_imm_form = byte_class == acc_alu_pkg::CLASS_IMM && grp_valid &&
                       byte_low == acc_alu_pkg::MEM_FIELD;

    // execution: operand and group of the current instruction
    wire in_opcode = state == acc_alu_pkg::ST_OPCODE;
    wire [2:0] cur_grp = in_opcode ? byte_grp : op_field;
    wire [7:0] operand = in_opcode ? gpr[byte_low] : mem_rdata;
    wire exec_fire = last_t && ((in_opcode && is_reg_form) ||
                                state == acc_alu_pkg::ST_IMMEDIATE ||
                                state == acc_alu_pkg::ST_OPERAND);
    wire [15:0] alu_out = alu(cur_grp, acc, operand, flags);
    wire cin_used = (cur_grp == acc_alu_pkg::GROUP_SUB_BORROW) & flags[acc_alu_pkg::FLAG_C];
    wire sub_type = cur_grp == acc_alu_pkg::GROUP_SUB ||
                    cur_grp == acc_alu_pkg::GROUP_SUB_BORROW;

    // apb decode
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire [7:0] a8 = paddr[7:0];
    wire addr_hi_zero = (paddr >> 8) == '0;
    wire gpr_hit = addr_hi_zero && a8 >= acc_alu_pkg::OFS_GPR_BASE &&
                   a8 <= acc_alu_pkg::OFS_GPR_LAST && a8[1:0] == 2'h0 &&
                   a8[4:2] != acc_alu_pkg::MEM_FIELD;
    wire [2:0] gpr_sel = a8[4:2];
    wire hit_ctrl = addr_hi_zero && a8 == acc_alu_pkg::OFS_CONTROL;
    wire hit_pc = addr_hi_zero && a8 == acc_alu_pkg::OFS_PC;
    wire hit_flags = addr_hi_zero && a8 == acc_alu_pkg::OFS_FLAGS;
    wire hit_first = addr_hi_zero && a8 == acc_alu_pkg::OFS_FIRST_INDEX;
    wire hit_second = addr_hi_zero && a8 == acc_alu_pkg::OFS_SECOND_INDEX;
    wire mapped = gpr_hit || hit_ctrl || hit_pc || hit_flags || hit_first || hit_second;
    wire data_write = pwrite && !hit_ctrl;
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (data_write && busy));
    wire wr_ok = access && pwrite && mapped && !(data_write && busy);
    wire go = wr_ok && hit_ctrl && pwdata[acc_alu_pkg::CTRL_GO_BIT] && !busy;
    wire [31:0] status = {30'h0, bad_opcode, busy};
    wire [31:0] rd_mux = hit_ctrl ? status :
                         hit_pc ? {16'h0, pc} :
                         hit_flags ? {24'h0, flags} :
                         hit_first ? {16'h0, first_index_register} :
                         hit_second ? {16'h0, second_index_register} :
                         gpr_hit ? {24'h0, gpr[gpr_sel]} : 32'h0;
    assign mem_rd = busy && state != acc_alu_pkg::ST_ADDRESS_CALC;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    // state machine: each state is one machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= acc_alu_pkg::ST_IDLE;
            tcnt <= 3'h0;
            mem_addr <= acc_alu_pkg::RESET_WORD;
            op_field <= 3'h0;
            use_second <= 1'b0;
            indexed <= 1'b0;
            disp <= acc_alu_pkg::RESET_BYTE;
            bad_opcode <= 1'b0;
            exec_done <= 1'b0;
        end else begin
            exec_done <= exec_fire;
            tcnt <= (last_t || !busy) ? 3'h0 : tcnt + 3'h1;
            if (go) begin
                state <= acc_alu_pkg::ST_OPCODE;
                mem_addr <= pc;
                bad_opcode <= 1'b0;
                indexed <= 1'b0;
            end else if (last_t) begin
                unique case (state)
                    acc_alu_pkg::ST_OPCODE: begin
                        op_field <= byte_grp;
                        mem_addr <= pc + 16'h0001;
                        use_second <= mem_rdata == acc_alu_pkg::PREFIX_SECOND;
                        if (is_prefix) begin
                            state <= acc_alu_pkg::ST_INDEXED_OPCODE;
                            indexed <= 1'b1;
                        end else if (is_imm_form) begin
                            state <= acc_alu_pkg::ST_IMMEDIATE;
                        end else if (is_ptr_form) begin
                            state <= acc_alu_pkg::ST_OPERAND;
                            mem_addr <= pointer_pair;
                        end else begin
                            state <= acc_alu_pkg::ST_IDLE;
                            bad_opcode <= !is_reg_form;
                        end
                    end
                    acc_alu_pkg::ST_INDEXED_OPCODE: begin
                        op_field <= byte_grp;
                        mem_addr <= pc + 16'h0001;
                        if (is_ptr_form) begin
                            state <= acc_alu_pkg::ST_DISPLACEMENT;
                        end else begin
                            state <= acc_alu_pkg::ST_IDLE;
                            bad_opcode <= 1'b1;
                        end
                    end
                    acc_alu_pkg::ST_DISPLACEMENT: begin
                        disp <= mem_rdata;
                        state <= acc_alu_pkg::ST_ADDRESS_CALC;
                    end
                    acc_alu_pkg::ST_ADDRESS_CALC: begin
                        mem_addr <= index_addr;
                        state <= acc_alu_pkg::ST_OPERAND;
                    end
                    acc_alu_pkg::ST_IMMEDIATE, acc_alu_pkg::ST_OPERAND: begin
                        state <= acc_alu_pkg::ST_IDLE;
                    end
                    acc_alu_pkg::ST_IDLE: state <= acc_alu_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // pc walks every byte taken from the instruction stream
    wire pc_step = last_t && (state == acc_alu_pkg::ST_OPCODE ||
                              state == acc_alu_pkg::ST_INDEXED_OPCODE ||
                              state == acc_alu_pkg::ST_DISPLACEMENT ||
                              state == acc_alu_pkg::ST_IMMEDIATE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= acc_alu_pkg::RESET_WORD;
            flags <= acc_alu_pkg::RESET_BYTE;
            first_index_register <= acc_alu_pkg::RESET_WORD;
            second_index_register <= acc_alu_pkg::RESET_WORD;
            for (int i = 0; i < 8; i++) begin
                gpr[i] <= acc_alu_pkg::RESET_BYTE;
            end
        end else begin
            if (pc_step) begin
                pc <= pc + 16'h0001;
            end else if (wr_ok && hit_pc) begin
                pc <= pwdata[15:0];
            end
            if (exec_fire) begin
                gpr[acc_alu_pkg::REG_ACC] <= alu_out[7:0];
                flags <= alu_out[15:8];
            end else if (wr_ok && hit_flags) begin
                flags <= pwdata[7:0];
            end else if (wr_ok && gpr_hit) begin
                gpr[gpr_sel] <= pwdata[7:0];
            end
            if (wr_ok && hit_first) begin
                first_index_register <= pwdata[15:0];
            end
            if (wr_ok && hit_second) begin
                second_index_register <= pwdata[15:0];
            end
        end
    end

    // checks
    logic [7:0] cyc_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt <= 8'h00;
        end else begin
            cyc_cnt <= go ? 8'h00 : (busy ? cyc_cnt + 8'h01 : cyc_cnt);
        end
    end

    AST_SUB_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && cur_grp == acc_alu_pkg::GROUP_SUB |=>
        acc == 8'($past(acc) - $past(operand)))
        else $error("subtract result wrong");
    AST_BORROW_SUB_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && cur_grp == acc_alu_pkg::GROUP_SUB_BORROW |=>
        acc == 8'($past(acc) - $past(operand) - {7'h00, $past(cin_used)}))
        else $error("borrow subtract result wrong");
    AST_AND_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && cur_grp == acc_alu_pkg::GROUP_AND |=>
        acc == ($past(acc) & $past(operand)) && flags[acc_alu_pkg::FLAG_H] &&
        !flags[acc_alu_pkg::FLAG_N] && !flags[acc_alu_pkg::FLAG_C])
        else $error("conjunction result or flags wrong");
    AST_OR_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && cur_grp == acc_alu_pkg::GROUP_OR |=>
        acc == ($past(acc) | $past(operand)) && !flags[acc_alu_pkg::FLAG_H] &&
        !flags[acc_alu_pkg::FLAG_PV] && !flags[acc_alu_pkg::FLAG_C])
        else $error("disjunction result or flags wrong");
    AST_SIGN_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire |=> flags[acc_alu_pkg::FLAG_Z] == (acc == 8'h00) &&
        flags[acc_alu_pkg::FLAG_S] == acc[7] && exec_done)
        else $error("sign or zero flag wrong");
    AST_BORROW: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && sub_type |=> flags[acc_alu_pkg::FLAG_N] &&
        flags[acc_alu_pkg::FLAG_C] == ({1'b0, $past(acc)} <
        ({1'b0, $past(operand)} + {8'h00, $past(cin_used)})))
        else $error("borrow flag wrong");
    AST_REG_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && in_opcode |-> cyc_cnt == 8'(acc_alu_pkg::REG_TOTAL_CYC - 1))
        else $error("register form length wrong");
    AST_SHORT_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && !in_opcode && !indexed |->
        cyc_cnt == 8'(acc_alu_pkg::SHORT_TOTAL_CYC - 1))
        else $error("short memory form length wrong");
    AST_INDEX_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && indexed |-> cyc_cnt == 8'(acc_alu_pkg::INDEX_TOTAL_CYC - 1))
        else $error("indexed form length wrong");
    AST_INDEX_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
        last_t && state == acc_alu_pkg::ST_ADDRESS_CALC |=>
        mem_rd && mem_addr == $past(index_val) + {{8{disp[7]}}, disp})
        else $error("indexed address wrong");
    AST_SUB_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && sub_type |=> flags[acc_alu_pkg::FLAG_H] == ({1'b0, $past(acc[3:0])} <
        ({1'b0, $past(operand[3:0])} + {4'h0, $past(cin_used)})) &&
        flags[acc_alu_pkg::FLAG_PV] == (($past(acc[7]) != $past(operand[7])) &&
        (acc[7] != $past(acc[7]))))
        else $error("subtract half borrow or overflow flag wrong");
    AST_AND_PV: assert property (@(posedge pclk) disable iff (!presetn)
        exec_fire && cur_grp == acc_alu_pkg::GROUP_AND |=> !flags[acc_alu_pkg::FLAG_PV])
        else $error("conjunction overflow flag not cleared");
    AST_IMM_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
        last_t && in_opcode && is_imm_form |=> mem_rd && mem_addr == $past(pc) + 16'h0001)
        else $error("immediate operand address wrong");
    AST_PTR_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
        last_t && in_opcode && is_ptr_form |=> mem_rd && mem_addr == $past(pointer_pair))
        else $error("pointer operand address wrong");
endmodule
`default_nettype wire

// ==== bench/mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    input wire logic pclk,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    // a released bus shows the inverse of the last byte, so stale data never matches
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
    always @(posedge pclk) begin
        if (mem_rd) begin
            last <= mem[mem_addr];
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd, exec_done, err;
    logic [7:0] paddr, mem_rdata, a, s, fin, d, op, exp_acc, exp_f;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] mem_addr, ptr;
    int num_errors = 0, comparisons = 0, cyc = 0, wr_cyc = 0, go_cyc = 0;
    logic [7:0] lat_q[$];
    logic [2:0] grp_tab [4] = '{3'h2, 3'h3, 3'h4, 3'h6};
    logic [2:0] reg_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

    accumulator_sub_and_or_alu i_accumulator_sub_and_or_alu (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .exec_done(exec_done));
    mem_model i_mem_model (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_cycles(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error latency expected %0d seen %0d", exp, got);
        end
    endtask

    // one apb transfer, entered just after a rising edge, ends one idle cycle later
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        wr_cyc = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask

    task automatic rd(input logic [7:0] ad);
        apb(1'b0, ad, 32'h0);
    endtask

    task automatic wait_idle();
        rd(8'h00);
        for (int n = 0; n < 60 && rdat[0] !== 1'b0; n++) rd(8'h00);
    endtask

    function automatic logic [15:0] model(input logic [2:0] g, input logic [7:0] x,
                                          input logic [7:0] y, input logic [7:0] f);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] nf;
        nf = f & 8'h28;
        case (g)
            3'h4: begin
                r = {1'b0, x & y};
                nf[4] = 1'b1;
            end
            3'h6: r = {1'b0, x | y};
            default: begin
                r = {1'b0, x} - {1'b0, y} - {8'h00, g[0] & f[0]};
                h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, g[0] & f[0]};
                nf[4] = h[4];
                nf[1] = 1'b1;
                nf[0] = r[8];
                nf[2] = (x[7] != y[7]) && (r[7] != x[7]);
            end
        endcase
        nf[7] = r[7];
        nf[6] = (r[7:0] == 8'h00);
        return {r[7:0], nf};
    endfunction

    // form: 0 register, 1 immediate, 2 pointer pair, 3 first index, 4 second index
    task automatic run_op(input logic [2:0] g, input int form, input logic [2:0] r);
        a = 8'($urandom);
        s = 8'($urandom);
        fin = 8'($urandom);
        d = 8'($urandom);
        ptr = 16'h8000 | 16'($urandom & 32'h0FFF);
        op = {form == 1 ? 2'h3 : 2'h2, g, form == 0 ? r : 3'h6};
        wr(8'h08, {24'h0, fin});
        wr(8'h04, 32'h100);
        i_mem_model.mem[16'h100] = op;
        i_mem_model.mem[16'h101] = s;
        case (form)
            0: if (r != 3'h7) wr(8'h20 + {3'h0, r, 2'h0}, {24'h0, s}); else s = a;
            2: begin
                wr(8'h30, {24'h0, ptr[15:8]});
                wr(8'h34, {24'h0, ptr[7:0]});
                i_mem_model.mem[ptr] = s;
            end
            3, 4: begin
                wr(form == 3 ? 8'h0C : 8'h10, {16'h0, ptr});
                i_mem_model.mem[16'h100] = (form == 3) ? 8'hDD : 8'hFD;
                i_mem_model.mem[16'h101] = op;
                i_mem_model.mem[16'h102] = d;
                i_mem_model.mem[ptr + {{8{d[7]}}, d}] = s;
            end
            default: ;
        endcase
        wr(8'h3C, {24'h0, a});
        {exp_acc, exp_f} = model(g, a, s, fin);
        lat_q.push_back(form == 0 ? 8'h04 : (form < 3 ? 8'h07 : 8'h13));
        wr(8'h00, 32'h1);
        go_cyc = wr_cyc;
        wait_idle();
        rd(8'h3C);
        check_byte("accumulator", exp_acc, rdat[7:0]);
        rd(8'h08);
        check_byte("flags", exp_f, rdat[7:0]);
    endtask

    // completion watcher: each pulse takes the oldest expected latency
    always @(posedge pclk) begin
        if (presetn && exec_done === 1'b1) begin
            if (lat_q.size() == 0) check_byte("stray_done", 8'h00, 8'h01);
            else check_cycles(lat_q.pop_front(), 8'(cyc - go_cyc - 1));
        end
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        void'($urandom(32'h257D));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h3C);
        check_byte("acc_reset", 8'h00, rdat[7:0]);
        rd(8'h38);
        check_byte("unmapped_err", 8'h01, {7'h0, err});
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 7; k++) run_op(grp_tab[g], 0, reg_tab[k]);
            for (int f = 1; f < 5; f++) run_op(grp_tab[g], f, 3'h0);
        end
        for (int g = 0; g < 4; g++) run_op(grp_tab[g], 3 + (g % 2), 3'h0);
        i_mem_model.mem[16'h100] = 8'h80;
        wr(8'h04, 32'h100);
        wr(8'h00, 32'h1);
        wait_idle();
        check_byte("bad_opcode", 8'h02, rdat[7:0] & 8'h03);
        repeat (30) @(posedge pclk);
        check_byte("pending_done", 8'h00, 8'(lat_q.size()));
        complete_run();
    end
endmodule
`default_nettype wire
